// *** rtl/cic_core_irq.v ***
// Purpose: Interrupt control register and request combiner for an 8-bit core
// Assumes: Inputs synchronous to clk_i; timer and peripherals live outside
// Notes:   Registers reached over AXI4-Lite; ext edge select at OPT bit 0
//
// Function
// [RULE1] Flags set on their events regardless of any enable bit.
// [RULE2] Software should clear a flag before enabling its interrupt.
// [RULE3] Global enable bit 7 passes unmasked interrupts; zero blocks all.
// [RULE4] Peripheral enable bit 6 required for any peripheral interrupt.
// [RULE5] Bit 5 enables the timer-zero overflow interrupt.
// [RULE6] Bit 4 enables the external pin interrupt.
// [RULE7] Bit 3 enables the port-change interrupt.
// [RULE8] A pin change counts only when its per-pin enable is set.
// [RULE9] Bit 2 set on timer-zero rollover, held until software clears.
// [RULE10] Reset leaves the timer count unchanged.
// [RULE11] Software should load the timer count before clearing its flag.
// [RULE12] Bit 1 set on external pin edge, held until cleared.
// [RULE13] Bit 0 set when any of pins 5..0 changes, held until cleared.
// [RULE14] Edge select one means rising edge, zero means falling.
// [RULE15] Request when global plus flagged source, or global plus peripheral and its enable; here a flagged source also needs its own enable bit.
// [RULE16] Reset clears bits 7..1; port-change flag left defined low here.
`timescale 1ns/1ps
`include "cic_map.vh"

module cic_core_irq #(
	parameter NPINS = 6
) (
	// Clock and reset
	input  wire              clk_i,
	input  wire              nrst_i,
	// AXI4-Lite write address
	input  wire [3:0]        s_axi_awaddr_i,
	input  wire              s_axi_awvalid_i,
	output reg               s_axi_awready_o,
	// AXI4-Lite write data
	input  wire [31:0]       s_axi_wdata_i,
	input  wire [3:0]        s_axi_wstrb_i,
	input  wire              s_axi_wvalid_i,
	output reg               s_axi_wready_o,
	// AXI4-Lite write response
	output reg  [1:0]        s_axi_bresp_o,
	output reg               s_axi_bvalid_o,
	input  wire              s_axi_bready_i,
	// AXI4-Lite read
	input  wire [3:0]        s_axi_araddr_i,
	input  wire              s_axi_arvalid_i,
	output reg               s_axi_arready_o,
	output reg  [31:0]       s_axi_rdata_o,
	output reg  [1:0]        s_axi_rresp_o,
	output reg               s_axi_rvalid_o,
	input  wire              s_axi_rready_i,
	// Event sources
	input  wire              timer_zero_rollover_i, // [RULE10]
	input  wire              external_irq_pin_i,
	input  wire [NPINS-1:0]  port_a_pins_i,
	input  wire              periph_irq_req_i,
	// Interrupt request
	output reg               core_irq_o
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	reg  [4:0]       en_q;
	wire [2:0]       flag_q;
	wire [7:0]       ctrl_q = {en_q, flag_q};
	reg              edge_sel_q;
	reg  [NPINS-1:0] pcen_q;
	reg              pin_q;
	reg  [NPINS-1:0] port_q;
	reg              prim_q;
	reg  [3:0]       awaddr_q;
	reg  [31:0]      wdata_q;
	reg              aw_have_q;
	reg              w_have_q;

	wire       global_irq_enable             = ctrl_q[`CIC_GIE_BIT];
	wire       peripheral_irq_enable         = ctrl_q[`CIC_PERIPHERAL_IRQ_ENABLE_BIT];
	wire       timer_zero_overflow_enable    = ctrl_q[`CIC_TZIE_BIT];
	wire       ext_pin_irq_enable            = ctrl_q[`CIC_EXIE_BIT];
	wire       port_change_irq_enable        = ctrl_q[`CIC_PCIE_BIT];
	wire       timer_zero_overflow_flag      = ctrl_q[`CIC_TZIF_BIT];
	wire       ext_pin_irq_flag              = ctrl_q[`CIC_EXIF_BIT];
	wire       port_change_irq_flag          = ctrl_q[`CIC_PCIF_BIT];

	// ----------------------------------------
	// Event detection
	// ----------------------------------------
	wire ext_evt  = prim_q & (edge_sel_q ? (external_irq_pin_i & ~pin_q)
	                                     : (~external_irq_pin_i & pin_q)); // [RULE14]
	wire [NPINS-1:0] pin_chg;
	genvar pi;
	generate
		for (pi = 0; pi < NPINS; pi = pi + 1) begin : g_pin
			assign pin_chg[pi] = (port_a_pins_i[pi] ^ port_q[pi]) & pcen_q[pi]; // [RULE8]
		end
	endgenerate
	wire pc_evt   = prim_q & |pin_chg; // [RULE13]
	wire [2:0] evt = {timer_zero_rollover_i, ext_evt, pc_evt}; // [RULE1] [RULE9]

	// ----------------------------------------
	// Event history
	// ----------------------------------------
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_q  <= 1'b0;
			port_q <= {NPINS{1'b0}};
			prim_q <= 1'b0;
		end else begin
			pin_q  <= external_irq_pin_i;
			port_q <= port_a_pins_i;
			prim_q <= 1'b1;
		end
	end

	// ----------------------------------------
	// Write channel
	// ----------------------------------------
	wire        wr_go    = aw_have_q & w_have_q & ~s_axi_bvalid_o;
	wire [3:0]  wa       = awaddr_q;
	wire [31:0] wd       = wdata_q;
	wire        sel_ctrl = (wa == `CIC_OFF_CTRL);
	wire        sel_opt  = (wa == `CIC_OFF_OPT);
	wire        sel_pcen = (wa == `CIC_OFF_PCEN);
	wire        sel_stat = (wa == `CIC_OFF_STAT);
	wire        wmap     = sel_ctrl | sel_opt | sel_pcen | sel_stat;

	reg  [3:0]  wstrb_q;
	wire        wr_b0    = wr_go & wstrb_q[0];
	wire        ctrl_wr  = wr_b0 & sel_ctrl;

	// ----------------------------------------
	// Enable, option and pin-enable registers
	// ----------------------------------------
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			en_q       <= `CIC_EN_RST; // [RULE16]
			edge_sel_q <= `CIC_OPT_RST;
			pcen_q     <= `CIC_PCEN_RST;
		end else begin
			if (ctrl_wr)
				en_q <= wd[7:3];
			if (wr_b0 && sel_opt)
				edge_sel_q <= wd[0];
			if (wr_b0 && sel_pcen)
				pcen_q <= wd[NPINS-1:0]; // [RULE8]
		end
	end

	// ----------------------------------------
	// Flags, set wins over clear
	// ----------------------------------------
	cic_flag #(
		.RST_VAL  (`CIC_TZIF_RST)
	) tz_flag_u (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.set_i    (evt[2]), // [RULE9]
		.wr_i     (ctrl_wr),
		.wr_val_i (wd[`CIC_TZIF_BIT]),
		.flag_o   (flag_q[2])
	);

	cic_flag #(
		.RST_VAL  (`CIC_EXIF_RST)
	) ex_flag_u (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.set_i    (evt[1]), // [RULE12]
		.wr_i     (ctrl_wr),
		.wr_val_i (wd[`CIC_EXIF_BIT]),
		.flag_o   (flag_q[1])
	);

	cic_flag #(
		.RST_VAL  (`CIC_PCIF_RST)
	) pc_flag_u (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.set_i    (evt[0]), // [RULE13]
		.wr_i     (ctrl_wr),
		.wr_val_i (wd[`CIC_PCIF_BIT]),
		.flag_o   (flag_q[0])
	);

	// ----------------------------------------
	// Write handshake
	// ----------------------------------------
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_have_q       <= 1'b0;
			w_have_q        <= 1'b0;
			awaddr_q        <= 4'h0;
			wdata_q         <= 32'h00000000;
			wstrb_q         <= 4'h0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `CIC_RESP_OKAY;
		end else begin
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o  <= 1'b0;
			if (s_axi_awvalid_i && !aw_have_q && !s_axi_awready_o && !wr_go) begin
				aw_have_q <= 1'b1;
				awaddr_q  <= s_axi_awaddr_i;
				s_axi_awready_o <= 1'b1;
			end
			if (s_axi_wvalid_i && !w_have_q && !s_axi_wready_o && !wr_go) begin
				w_have_q <= 1'b1;
				wdata_q  <= s_axi_wdata_i;
				wstrb_q  <= s_axi_wstrb_i;
				s_axi_wready_o <= 1'b1;
			end
			if (wr_go && aw_have_q && w_have_q) begin
				aw_have_q      <= 1'b0;
				w_have_q       <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wmap ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
			end else if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read channel
	// ----------------------------------------
	reg [31:0] rd_d;
	reg        rmap;
	always @* begin
		rmap = 1'b1;
		case (s_axi_araddr_i)
			`CIC_OFF_CTRL: rd_d = {24'h000000, ctrl_q};
			`CIC_OFF_OPT:  rd_d = {31'h00000000, edge_sel_q};
			`CIC_OFF_PCEN: rd_d = {{(32-NPINS){1'b0}}, pcen_q};
			`CIC_OFF_STAT: rd_d = {31'h00000000, core_irq_o};
			default: begin
				rd_d = 32'h00000000;
				rmap = 1'b0;
			end
		endcase
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h00000000;
			s_axi_rresp_o   <= `CIC_RESP_OKAY;
		end else begin
			s_axi_arready_o <= 1'b0;
			if (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o) begin
				s_axi_arready_o <= 1'b1;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_d;
				s_axi_rresp_o   <= rmap ? `CIC_RESP_OKAY : `CIC_RESP_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Interrupt request
	// ----------------------------------------
	wire tz_src   = timer_zero_overflow_flag & timer_zero_overflow_enable; // [RULE5]
	wire ex_src   = ext_pin_irq_flag & ext_pin_irq_enable; // [RULE6]
	wire pc_src   = port_change_irq_flag & port_change_irq_enable; // [RULE7]
	wire core_src = tz_src | ex_src | pc_src;
	wire per_src  = periph_irq_req_i & peripheral_irq_enable; // [RULE4]

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			core_irq_o <= 1'b0;
		else
			core_irq_o <= global_irq_enable & (core_src | per_src); // [RULE3] [RULE15]
	end

endmodule

// ----------------------------------------
// Sticky flag, set wins over clear
// ----------------------------------------
module cic_flag #(
	parameter [0:0] RST_VAL = 1'b0
) (
	// Clock and reset
	input  wire clk_i,
	input  wire nrst_i,
	// Event and software write
	input  wire set_i,
	input  wire wr_i,
	input  wire wr_val_i,
	// Flag state
	output reg  flag_o
);

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i)
			flag_o <= RST_VAL;
		else if (set_i)
			flag_o <= 1'b1; // [RULE1]
		else if (wr_i)
			flag_o <= wr_val_i;
	end

endmodule

// *** rtl/cic_map.vh ***
// Purpose: Register map and field positions for the core interrupt control block
// Assumes: AXI4-Lite with 32-bit data, one register per aligned word
// Notes:   Upper bits of every register read as zero
`ifndef CIC_MAP_VH
`define CIC_MAP_VH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define CIC_OFF_CTRL     4'h0
`define CIC_OFF_OPT      4'h4
`define CIC_OFF_PCEN     4'h8
`define CIC_OFF_STAT     4'hC

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CIC_GIE_BIT      7
`define CIC_PERIPHERAL_IRQ_ENABLE_BIT     6
`define CIC_TZIE_BIT     5
`define CIC_EXIE_BIT     4
`define CIC_PCIE_BIT     3
`define CIC_TZIF_BIT     2
`define CIC_EXIF_BIT     1
`define CIC_PCIF_BIT     0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CIC_CTRL_RST     7'h00
`define CIC_EN_RST       5'h00
`define CIC_TZIF_RST     1'h0
`define CIC_EXIF_RST     1'h0
`define CIC_OPT_RST      1'h1
`define CIC_PCEN_RST     6'h00
`define CIC_PCIF_RST     1'h0
`define CIC_RESP_OKAY    2'h0
`define CIC_RESP_SLVERR  2'h2

`endif

// *** verif/cic_core_irq_bench.sv ***
// Purpose: Self-checking bench for cic_core_irq
// Assumes: Bus answers per hand-over timing
// Notes:   Expected bus results queued, checked by monitor
`timescale 1ns/1ps
`define CHK(n,e,s) begin tests_run++; if ((s) !== (e)) begin n_mismatch++; $display("MISMATCH %s exp %h seen %h", n, e, s); end end
module cic_core_irq_bench;
	logic        clk_i = 1'b0, nrst_i = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
	logic        rready = 1'b0, periph = 1'b0, awready, wready, bvalid, arready, rvalid, irq, tmr, pin;
	logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  bresp, rresp;
	logic [5:0]  port;
	logic [7:0]  kick = 8'h00;
	logic [33:0] exp_q[$], e;
	int          n_mismatch = 0, tests_run = 0, cyc = 0;
	always #5 clk_i = ~clk_i;
	cic_src_model src_u (.clk_i(clk_i), .kick_i(kick), .tmr_o(tmr), .pin_o(pin), .port_o(port));
	cic_core_irq dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
		.s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .timer_zero_rollover_i(tmr),
		.external_irq_pin_i(pin), .port_a_pins_i(port), .periph_irq_req_i(periph), .core_irq_o(irq));
	task wrap_up;
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		exp_q.push_back({r, 32'h0});
		@(posedge clk_i);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
		while (!(aw_done && w_done)) begin
			@(posedge clk_i);
			if (awready === 1'b1 && !aw_done) begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (wready === 1'b1 && !w_done) begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		while (bvalid !== 1'b1)
			@(posedge clk_i);
		bready <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
		exp_q.push_back({r, d});
		@(posedge clk_i);
		{araddr, arvalid, rready} <= {a, 2'h3};
		do @(posedge clk_i); while (arready !== 1'b1);
		arvalid <= 1'b0;
		while (rvalid !== 1'b1)
			@(posedge clk_i);
		rready <= 1'b0;
	endtask
	task kk(input logic [7:0] m);
		@(posedge clk_i);
		kick <= m;
		@(posedge clk_i);
		kick <= 8'h00;
		repeat (3) @(posedge clk_i);
	endtask
	task fire;
		kk({6'(($urandom % 63) + 1), 2'h3});
		kk(8'h02);
	endtask
	task irq_is(input logic x);
		repeat (2) @(posedge clk_i);
		#1 `CHK("irq", x, irq)
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (cyc > 4000) begin
			n_mismatch++;
			wrap_up();
		end
		if (bvalid === 1'b1 && bready) begin
			e = exp_q.pop_front();
			`CHK("bresp", e, {bresp, 32'h0})
		end
		if (rvalid === 1'b1 && rready) begin
			e = exp_q.pop_front();
			`CHK("rdata", e, {rresp, rdata})
		end
	end
	initial begin
		void'($urandom(84));
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h4, 32'h1, 2'h0);
		rd(4'h8, 32'h0, 2'h0);
		rd(4'h2, 32'h0, 2'h2);
		$display("test reset done");
		fire();
		rd(4'h0, 32'h6, 2'h0);
		irq_is(1'b0);
		wr(4'h8, 32'h3F, 2'h0);
		wr(4'h0, 32'h0, 2'h0);
		fire();
		rd(4'h0, 32'h7, 2'h0);
		wr(4'h0, 32'h0, 2'h0);
		wr(4'h4, 32'h0, 2'h0);
		kk(8'h02);
		rd(4'h0, 32'h0, 2'h0);
		kk(8'h02);
		rd(4'h0, 32'h2, 2'h0);
		$display("test flags done");
		for (int i = 0; i < 3; i++) begin
			wr(4'h0, 32'h0, 2'h0);
			fire();
			wr(4'h0, 32'h87 | (32'h8 << i), 2'h0);
			irq_is(1'b1);
			rd(4'hC, 32'h1, 2'h0);
			wr(4'h0, 32'h7 | (32'h8 << i), 2'h0);
			irq_is(1'b0);
			wr(4'h0, (32'h87 | (32'h8 << i)) & ~(32'h1 << i), 2'h0);
			irq_is(1'b0);
		end
		$display("test enables done");
		wr(4'h0, 32'h80, 2'h0);
		@(posedge clk_i) periph <= 1'b1;
		irq_is(1'b0);
		wr(4'h0, 32'hC0, 2'h0);
		irq_is(1'b1);
		@(posedge clk_i) periph <= 1'b0;
		irq_is(1'b0);
		$display("test periph done");
		fire();
		@(posedge clk_i) nrst_i <= 1'b0;
		@(posedge clk_i) nrst_i <= 1'b1;
		rd(4'h0, 32'h0, 2'h0);
		rd(4'h4, 32'h1, 2'h0);
		$display("test rerun done");
		wrap_up();
	end
endmodule

// *** verif/cic_core_irq_props.sv ***
// Purpose: Port checker for cic_core_irq
// Assumes: One clock, async active-low reset
// Notes:   Bound after the module
`timescale 1ns/1ps
module cic_chk (
	// Clock and reset
	input wire logic        clk_i,
	input wire logic        nrst_i,
	// Bus
	input wire logic        s_axi_awready_o,
	input wire logic        s_axi_wready_o,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [3:0]  s_axi_araddr_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	// Interrupt
	input wire logic        periph_irq_req_i,
	input wire logic        core_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	a_bvalid_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("bvalid hold");
	a_rvalid_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("rvalid hold");
	a_read_answer: assert property (s_axi_arvalid_i && !s_axi_arready_o && !s_axi_rvalid_o
		|=> s_axi_arready_o && s_axi_rvalid_o) else $error("read answer");
	a_write_resp: assert property (s_axi_awready_o && s_axi_wready_o |=> s_axi_bvalid_o && !s_axi_awready_o)
		else $error("write response");
	a_arready_pulse: assert property (s_axi_arready_o |=> !s_axi_arready_o) else $error("arready pulse");
	a_irq_reset_low: assert property ($rose(nrst_i) |-> !core_irq_o) else $error("irq after reset");
	a_status_mirror: assert property (s_axi_arvalid_i && s_axi_araddr_i == 4'hC && !s_axi_arready_o
		&& !s_axi_rvalid_o |=> s_axi_rdata_o == {31'h0, $past(core_irq_o)}) else $error("status");
	a_irq_sticky: assert property ($fell(core_irq_o) |-> $past(s_axi_awready_o, 2)
		|| $past(s_axi_awready_o) || !$past(periph_irq_req_i)) else $error("irq dropped");
endmodule
bind cic_core_irq cic_chk u_chk (.clk_i, .nrst_i, .s_axi_awready_o, .s_axi_wready_o, .s_axi_bresp_o,
	.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
	.s_axi_rvalid_o, .s_axi_rready_i, .periph_irq_req_i, .core_irq_o);

// *** verif/cic_src_model.sv ***
// Purpose: Timer and pin event source model
// Assumes: kick_i held one cycle per request
// Notes:   Rollover is a one-cycle pulse, pins are levels
`timescale 1ns/1ps
module cic_src_model (
	// Clock and command
	input  wire logic       clk_i,
	input  wire logic [7:0] kick_i,
	// Events
	output logic            tmr_o = 1'b0,
	output logic            pin_o = 1'b0,
	output logic [5:0]      port_o = 6'h00
);
	always @(posedge clk_i) begin
		tmr_o <= kick_i[0];
		pin_o <= pin_o ^ kick_i[1];
		port_o <= port_o ^ kick_i[7:2];
	end
endmodule
